// [pkg/dsp_pkg.sv]
// Constants and carrier types for the two-word burst DDR SRAM port.
// Assumes one input clock domain (clk_i) and one output clock domain (link clock).
package dsp_pkg;
  localparam int DSP_DATA_W = 18;
  localparam int DSP_ADDR_W = 6;
  localparam logic [1:0] DSP_PHASE_ADDR = 2'h0;
  localparam logic [1:0] DSP_PHASE_LAT_FULL = 2'h2;
  localparam logic [1:0] DSP_PHASE_LAT_HALF = 2'h3;
  // Half cycles in which the two write words are taken from the data pins
  localparam logic [1:0] DSP_PHASE_WORD0 = 2'h2;
  localparam logic [1:0] DSP_PHASE_WORD1 = 2'h3;

  typedef enum logic [1:0] {
    DSP_IDLE  = 2'b00,
    DSP_READ  = 2'b01,
    DSP_WRITE = 2'b10
  } dsp_op_t;

  typedef struct packed {
    dsp_op_t               op;
    logic [DSP_ADDR_W-1:0] addr;
  } dsp_cmd_t;
endpackage : dsp_pkg

// [hw/dsp_sram_port.sv]
// Device-side logic of a two-word burst DDR SRAM port with a small array.
// Assumes clk_i is the main input timing clock (each rising edge is one half cycle:
// even edges stand for the true clock, odd edges for its complement) and that
// out_clk_i is the output timing clock, asynchronous to clk_i unless the caller ties it to clk_i when no output clock is present.
`timescale 1ns/1ps
module dsp_sram_port
  import dsp_pkg::*;
#(
  parameter int DATA_W = DSP_DATA_W,
  parameter int ADDR_W = DSP_ADDR_W
) (
  // Input clock domain
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Memory command pins
  input  wire logic              load_n_i,
  input  wire logic              read_not_write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              pll_bypass_select_i,
  input  wire logic              out_clk_present_i,
  // Shared data pins
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe_o,
  // Output clock domain
  input  wire logic              out_clk_i,
  input  wire logic              out_reset_n_i,
  output logic                   echo_strobe_o,
  output logic                   echo_strobe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling, two flops on every command and data pin except out_clk_present_i
  logic              load_n_s1, load_n_s2, rnw_s1, rnw_s2, byp_s1, byp_s2;
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic [DATA_W-1:0] dq_s1, dq_s2;

  always_ff @(posedge clk_i) begin
    load_n_s1 <= load_n_i;
    load_n_s2 <= load_n_s1;
    rnw_s1    <= read_not_write_i;
    rnw_s2    <= rnw_s1;
    byp_s1    <= pll_bypass_select_i;
    byp_s2    <= byp_s1;
    addr_s1   <= addr_i;
    addr_s2   <= addr_s1;
    dq_s1     <= dq_i;
    dq_s2     <= dq_s1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase: bit 0 marks the complement half, bits count half cycles of an access
  logic [1:0] phase;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase <= DSP_PHASE_ADDR;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Address only on alternate true-clock edges
  logic addr_slot;
  assign addr_slot = (phase == DSP_PHASE_ADDR);

  dsp_cmd_t cmd;
  logic     burst_lsb;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cmd       <= '{op: DSP_IDLE, addr: '0};
      burst_lsb <= 1'b0;
    end else if (addr_slot) begin
      cmd.op    <= load_n_s2 ? DSP_IDLE : (rnw_s2 ? DSP_READ : DSP_WRITE);
      cmd.addr  <= addr_s2;
      burst_lsb <= addr_s2[0];
    end else if (phase == DSP_PHASE_WORD0) begin
      // Flips once the first word is placed, so the write address follows the data
      burst_lsb <= ~burst_lsb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array with self-timed writes: each captured word is written one edge later
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] wr_word;
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_pend;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'b0;
      wr_word <= '0;
      wr_addr <= '0;
    end else begin
      wr_pend <= (cmd.op == DSP_WRITE) && ((phase == DSP_PHASE_WORD0) || (phase == DSP_PHASE_WORD1));
      wr_word <= dq_s2;
      wr_addr <= {cmd.addr[ADDR_W-1:1], burst_lsb};
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_pend) begin
      mem[wr_addr] <= wr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read launch: word pair latched at the latency edge chosen by bypass select
  logic              rd_go;
  logic [DATA_W-1:0] rd_w0, rd_w1;
  logic              rd_tog;

  assign rd_go = (cmd.op == DSP_READ) &&
                 (phase == (byp_s2 ? DSP_PHASE_LAT_HALF : DSP_PHASE_LAT_FULL));

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_tog <= 1'b0;
      rd_w0  <= '0;
      rd_w1  <= '0;
    end else if (rd_go) begin
      rd_w0  <= mem[{cmd.addr[ADDR_W-1:1], cmd.addr[0]}];
      rd_w1  <= mem[{cmd.addr[ADDR_W-1:1], ~cmd.addr[0]}];
      rd_tog <= ~rd_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output domain: toggle crossing; words stable while toggle settles
  logic       tog_s1, tog_s2, tog_s3;
  logic [1:0] out_cnt;
  logic       clk_sel_s1, clk_sel_s2;

  always_ff @(posedge out_clk_i) begin
    if (!out_reset_n_i) begin
      tog_s1     <= 1'b0;
      tog_s2     <= 1'b0;
      tog_s3     <= 1'b0;
      clk_sel_s1 <= 1'b0;
      clk_sel_s2 <= 1'b0;
    end else begin
      tog_s1     <= rd_tog;
      tog_s2     <= tog_s1;
      tog_s3     <= tog_s2;
      clk_sel_s1 <= out_clk_present_i;
      clk_sel_s2 <= clk_sel_s1;
    end
  end

  // Without an output clock the caller ties out_clk_i to clk_i
  always_ff @(posedge out_clk_i) begin
    if (!out_reset_n_i) begin
      out_cnt         <= 2'h0;
      dq_o            <= '0;
      dq_oe_o         <= 1'b0;
      echo_strobe_o   <= 1'b0;
      echo_strobe_n_o <= 1'b1;
    end else if (tog_s2 != tog_s3) begin
      out_cnt         <= 2'h1;
      dq_o            <= rd_w0;
      dq_oe_o         <= 1'b1;
      echo_strobe_o   <= 1'b1;
      echo_strobe_n_o <= 1'b0;
    end else if (out_cnt == 2'h1) begin
      out_cnt         <= 2'h2;
      dq_o            <= rd_w1;
      echo_strobe_o   <= 1'b0;
      echo_strobe_n_o <= 1'b1;
    end else begin
      out_cnt         <= 2'h0;
      dq_oe_o         <= 1'b0;
      echo_strobe_o   <= 1'b0;
      echo_strobe_n_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence read_taken_s;
    addr_slot && !load_n_s2 && rnw_s2;
  endsequence

  addr_alternate_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    addr_slot |=> !addr_slot ##1 !addr_slot ##1 !addr_slot) else $error("address slot not one in four");

  full_latency_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (read_taken_s ##1 !byp_s2 ##1 !byp_s2) |-> rd_go) else $error("full latency read not launched");

  half_latency_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (read_taken_s ##1 byp_s2 ##1 byp_s2 ##1 byp_s2) |-> rd_go) else $error("half latency read not launched");

  burst_flip_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (phase == DSP_PHASE_WORD0) |=> burst_lsb != $past(burst_lsb)) else $error("burst lsb not complemented");

  write_commit_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_pend |=> mem[$past(wr_addr)] == $past(wr_word)) else $error("write not committed");

  echo_align_a : assert property (@(posedge out_clk_i) disable iff (!out_reset_n_i)
    echo_strobe_o |-> dq_oe_o && !echo_strobe_n_o) else $error("echo strobe without data");

  read_pair_a : assert property (@(posedge out_clk_i) disable iff (!out_reset_n_i)
    $rose(echo_strobe_o) |=> dq_oe_o ##1 !dq_oe_o) else $error("read burst not two words");

  lsb_load_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    addr_slot |=> burst_lsb == $past(addr_s2[0])) else $error("burst counter load wrong");

  // Write words land at the taken address first, then at its LSB partner
  sequence write_taken_s;
    addr_slot && !load_n_s2 && !rnw_s2;
  endsequence

  write_order_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    write_taken_s |-> ##3 (wr_pend && wr_addr == $past(addr_s2, 3))
    ##1 (wr_pend && wr_addr[0] != $past(addr_s2[0], 4))) else $error("write burst order wrong");

  echo_pair_a : assert property (@(posedge out_clk_i) disable iff (!out_reset_n_i)
    echo_strobe_n_o == !echo_strobe_o) else $error("echo strobes not complementary");

  // Read data only leaves after the crossing toggle has been seen
  launch_reg_a : assert property (@(posedge out_clk_i) disable iff (!out_reset_n_i)
    $rose(dq_oe_o) |-> $past(tog_s2 != tog_s3)) else $error("read launched without toggle");

endmodule : dsp_sram_port

// [test/dsp_ctl_model.sv]
// Controller-side model of the shared data pins.
// Assumes the bench drives ctl_oe_i and ctl_dq_i on falling clk_i edges.
`timescale 1ns/1ps
module dsp_ctl_model
  import dsp_pkg::*;
(
  // Clock
  input  wire logic                  clk_i,
  // Drivers of the pins
  input  wire logic                  ctl_oe_i,
  input  wire logic [DSP_DATA_W-1:0] ctl_dq_i,
  input  wire logic                  dq_oe_i,
  input  wire logic [DSP_DATA_W-1:0] dq_i,
  // Resolved pin level
  output logic      [DSP_DATA_W-1:0] pin_o
);
  logic [DSP_DATA_W-1:0] last;
  // Released pins show the inverse, so a stale word cannot pass
  always_comb pin_o = ctl_oe_i ? ctl_dq_i : (dq_oe_i ? dq_i : ~last);
  always_ff @(posedge clk_i) last <= pin_o;
endmodule : dsp_ctl_model

// [test/ddr_two_word_burst_sram_port_bench.sv]
// Bench for the two-word burst SRAM port: burst writes, then reads in both latency modes.
// Assumes slots fall on every fourth clk_i edge after reset release.
`timescale 1ns/1ps
module ddr_two_word_burst_sram_port_bench;
  import dsp_pkg::*;
  logic                  clk_i = 0, out_clk_i = 0, reset_n_i = 0, load_n = 1, rnw = 1, bypass = 0, ctl_oe = 0;
  logic [DSP_ADDR_W-1:0] addr = '0;
  logic [DSP_DATA_W-1:0] ctl_dq = '0, dq_i, dq_o;
  logic                  dq_oe_o, echo_strobe_o, echo_strobe_n_o;
  logic [3:0]            ph = '0;
  int                    errors = 0, num_checks = 0;
  logic                  one_clk = 0;
  wire                   link_clk = one_clk ? clk_i : out_clk_i;
  always #12.5 clk_i = ~clk_i;
  initial #3 forever #16 out_clk_i = ~out_clk_i;
  always @(posedge clk_i) ph <= reset_n_i ? ph + 4'h1 : 4'h0;
  dsp_sram_port DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_n_i(load_n), .read_not_write_i(rnw),
    .addr_i(addr), .pll_bypass_select_i(bypass), .out_clk_present_i(!one_clk), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .out_clk_i(link_clk), .out_reset_n_i(reset_n_i), .echo_strobe_o(echo_strobe_o),
    .echo_strobe_n_o(echo_strobe_n_o));
  dsp_ctl_model ctl (.clk_i(clk_i), .ctl_oe_i(ctl_oe), .ctl_dq_i(ctl_dq), .dq_oe_i(dq_oe_o), .dq_i(dq_o),
    .pin_o(dq_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [DSP_DATA_W-1:0] exp, input logic [DSP_DATA_W-1:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Lands on the falling edge just after a slot edge
  task automatic align();
    int n;
    @(negedge clk_i);
    for (n = 0; n < 8 && ph[1:0] != 2'h1; n++) @(negedge clk_i);
    if (ph[1:0] != 2'h1) begin
      errors++;
      stop_test();
    end
  endtask : align
  // Command held over four edges, taken at the next slot only
  task automatic access(input logic rd, input logic [DSP_ADDR_W-1:0] a, input logic [DSP_DATA_W-1:0] w0, w1);
    align();
    load_n = 1'b0;
    rnw = rd;
    addr = a;
    repeat (3) @(negedge clk_i);
    ctl_oe = !rd;
    ctl_dq = w0;
    @(negedge clk_i);
    load_n = 1'b1;
    ctl_dq = w1;
    @(negedge clk_i);
    ctl_oe = 1'b0;
  endtask : access
  task automatic rd_burst(input logic [DSP_ADDR_W-1:0] a, input logic [DSP_DATA_W-1:0] e0, e1);
    int n;
    access(1'b1, a, '0, '0);
    for (n = 0; n < 24 && dq_oe_o !== 1'b1; n++) @(negedge link_clk);
    if (dq_oe_o !== 1'b1) begin
      errors++;
      stop_test();
    end
    check("word0", e0, dq_o);
    check("pin0", e0, dq_i);
    check("strobe0", DSP_DATA_W'(2'h2), DSP_DATA_W'({echo_strobe_o, echo_strobe_n_o}));
    @(negedge link_clk);
    check("word1", e1, dq_o);
    check("strobe1", DSP_DATA_W'(2'h1), DSP_DATA_W'({echo_strobe_o, echo_strobe_n_o}));
    @(negedge link_clk);
    check("release", '0, DSP_DATA_W'(dq_oe_o));
  endtask : rd_burst
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    access(1'b0, 6'h05, 18'h2a5a5, 18'h1c3c3);
    rd_burst(6'h05, 18'h2a5a5, 18'h1c3c3);
    rd_burst(6'h04, 18'h1c3c3, 18'h2a5a5);
    bypass = 1'b1;
    access(1'b0, 6'h3e, 18'h3ffff, 18'h00001);
    rd_burst(6'h3f, 18'h00001, 18'h3ffff);
    // Single clock: switched while clk_i is low so no false link edge appears
    @(negedge clk_i);
    one_clk = 1'b1;
    rd_burst(6'h05, 18'h2a5a5, 18'h1c3c3);
    stop_test();
  end
  // Guard against a stalled run
  initial begin
    #50000;
    errors++;
    stop_test();
  end
endmodule : ddr_two_word_burst_sram_port_bench
